// ==== design/ccp_shared_command_engine.sv ====
// Shared command engine: collects command bytes from both ports, checks
// them, runs the command and hands the answer bytes to one port.
// Assumes the byte layers deliver one-cycle byte strobes and an
// end-of-frame pulse per command; all inputs except rst are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ccp_shared_command_engine #(
  parameter int WINDOW_CYC = ccp_pkg::WINDOW_CYCLES,
  parameter int NV_WRITE_CYC = ccp_pkg::NV_WRITE_CYCLES,
  parameter logic [7:0] PROJECT_NUMBER = 8'h11, // Arbitrary value
  parameter logic [11:0] FAMILY_CODE = 12'h123, // Arbitrary value
  parameter logic [3:0] HW_VERSION = 4'h1,
  parameter logic [7:0] SW_VERSION = 8'h01,
  parameter logic [15:0] ROM_CHECKSUM = 16'h0000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Command bytes from the ports
  input wire ccp_pkg::ccp_byte_t twoWireByte,
  input wire ccp_pkg::ccp_byte_t singleWireByte,
  input wire logic cmdEnd,
  // Answer bytes to the ports
  output ccp_pkg::ccp_byte_t answerByte,
  input wire logic answerTaken,
  output logic answerReady,
  output logic singleWireEnable,
  // Device state
  input wire logic unlockedBlock,
  input wire logic enabledError,
  output logic configMode,
  output logic diagMode,
  // Register file
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // Nonvolatile memory
  output ccp_pkg::ccp_nv_req_t nvStore,
  output logic [6:0] nvReadAddr,
  input wire logic [15:0] nvRdata,
  input wire logic [31:0] identWords,
  // Measurement path
  output logic measStart,
  output logic [1:0] measKind,
  output logic [1:0] measSel,
  output logic [7:0] testStimulus,
  input wire logic measDone,
  input wire logic [15:0] measWord0,
  input wire logic [15:0] measWord1
);
  typedef struct packed {
    ccp_pkg::ccp_phase_t phase;
    ccp_pkg::ccp_mode_t mode;
    logic [31:0] winCnt;
    logic [31:0] waitCnt;
    logic [2:0] nBytes;
    logic [7:0][7:0] cmd;
    logic anyTwoWire;
    logic [6:0][7:0] ans;
    logic [2:0] ansLen;
    logic [2:0] ansIdx;
    logic toTwoWire;
    logic regWr;
    ccp_pkg::ccp_nv_req_t nv;
    logic measGo;
  } ccp_state_t;

  ccp_state_t s_q, s_d;

  function automatic logic [7:0] sumPlusOne(input logic [6:0][7:0] b,
                                            input logic [2:0] n);
    logic [7:0] acc;
    acc = 8'h01;
    for (int i = 0; i < 7; i++) begin
      if (3'(i) < n) begin
        acc = acc + b[i];
      end
    end
    return acc;
  endfunction

  logic [6:0][7:0] cmdBytes;
  logic sumOk;
  logic inCfg;
  logic inAny;
  logic [7:0] a1;

  always_comb begin
    cmdBytes = s_q.cmd[6:0];
    sumOk = s_q.nBytes >= 3'd2 &&
            sumPlusOne(cmdBytes, s_q.nBytes - 3'd1) ==
            s_q.cmd[s_q.nBytes - 3'd1]; // R22
    inCfg = s_q.mode == ccp_pkg::CCP_CONFIG;
    inAny = inCfg || s_q.mode == ccp_pkg::CCP_DIAG;
    a1 = s_q.cmd[1];
  end

  always_comb begin
    s_d = s_q;
    s_d.regWr = 1'b0;
    s_d.nv.valid = 1'b0;
    s_d.measGo = 1'b0;
    if (s_q.mode == ccp_pkg::CCP_WINDOW) begin
      if (s_q.winCnt >= 32'(WINDOW_CYC - 1)) begin
        s_d.mode = ccp_pkg::CCP_OPER; // R24
      end else begin
        s_d.winCnt = s_q.winCnt + 32'd1;
      end
    end
    case (s_q.phase)
      ccp_pkg::CCP_IDLE: begin
        if (twoWireByte.valid && s_q.nBytes < 3'(ccp_pkg::MAX_CMD)) begin
          s_d.cmd[s_q.nBytes] = twoWireByte.data;
          s_d.nBytes = s_q.nBytes + 3'd1;
          s_d.anyTwoWire = 1'b1; // R20
        end else if (singleWireByte.valid && singleWireEnable &&
                     s_q.nBytes < 3'(ccp_pkg::MAX_CMD)) begin
          s_d.cmd[s_q.nBytes] = singleWireByte.data; // R21
          s_d.nBytes = s_q.nBytes + 3'd1;
        end
        if (cmdEnd) begin
          s_d.phase = ccp_pkg::CCP_EXEC;
        end
      end
      ccp_pkg::CCP_EXEC: begin
        s_d.toTwoWire = s_q.anyTwoWire; // R20
        s_d.ans = '0;
        s_d.ans[0] = ccp_pkg::ANS_NACK; // R25
        s_d.ansLen = 3'd1;
        s_d.ansIdx = 3'd0;
        s_d.phase = ccp_pkg::CCP_REPLY;
        case (s_q.cmd[0])
          ccp_pkg::CMD_ENTER_CONFIG, ccp_pkg::CMD_ENTER_DIAG: begin
            if (s_q.nBytes == 3'd4 && sumOk &&
                s_q.cmd[1] == ccp_pkg::KEY_BYTE0 &&
                s_q.cmd[2] == ccp_pkg::KEY_BYTE1 &&
                s_q.mode == ccp_pkg::CCP_WINDOW) begin // R05
              if (s_q.cmd[0] == ccp_pkg::CMD_ENTER_DIAG) begin
                s_d.mode = ccp_pkg::CCP_DIAG; // R03
                s_d.ans[0] = ccp_pkg::ANS_ACK; // R04
              end else if (unlockedBlock) begin // R02
                s_d.mode = ccp_pkg::CCP_CONFIG; // R01
                s_d.ans[0] = ccp_pkg::ANS_ACK; // R04
              end
            end
          end
          ccp_pkg::CMD_REG_READ: begin
            if (s_q.nBytes == 3'd3 && sumOk && inAny &&
                a1 >= ccp_pkg::REG_ADDR_LO && a1 <= ccp_pkg::REG_ADDR_HI) begin
              s_d.ans[0] = ccp_pkg::ANS_ACK; // R06
              s_d.ans[1] = regRdata;
              s_d.ansLen = 3'd2;
            end
          end
          ccp_pkg::CMD_REG_WRITE: begin
            if (s_q.nBytes == 3'd4 && sumOk && inCfg &&
                a1 >= ccp_pkg::REG_ADDR_LO && a1 <= ccp_pkg::REG_ADDR_HI) begin
              s_d.regWr = 1'b1; // R07
              s_d.ans[0] = ccp_pkg::ANS_ACK;
            end
          end
          ccp_pkg::CMD_NV_FETCH: begin
            if (s_q.nBytes == 3'd3 && sumOk && inAny &&
                a1 <= ccp_pkg::NV_READ_HI) begin
              s_d.ans[0] = ccp_pkg::ANS_ACK; // R08
              s_d.ans[1] = nvRdata[15:8];
              s_d.ans[2] = nvRdata[7:0];
              s_d.ansLen = 3'd3;
            end
          end
          ccp_pkg::CMD_NV_STORE: begin
            if (s_q.nBytes == 3'd5 && sumOk && inCfg &&
                a1 <= ccp_pkg::NV_WRITE_HI) begin // R09
              s_d.nv.valid = 1'b1;
              s_d.nv.addr = a1[6:0];
              s_d.nv.data = {s_q.cmd[2], s_q.cmd[3]};
              s_d.waitCnt = '0;
              s_d.phase = ccp_pkg::CCP_NVWAIT;
            end
          end
          ccp_pkg::CMD_SELF_TEST, ccp_pkg::CMD_PRESSURE,
          ccp_pkg::CMD_TEMPERATURE: begin
            if (sumOk && inAny &&
                s_q.nBytes == (s_q.cmd[0] == ccp_pkg::CMD_SELF_TEST ?
                               3'd4 : 3'd3)) begin
              s_d.measGo = 1'b1; // R11 R12 R15
              s_d.phase = ccp_pkg::CCP_MEASWAIT;
            end
          end
          ccp_pkg::CMD_DEV_IDENT: begin
            if (s_q.nBytes == 3'd2 && sumOk && inAny) begin
              s_d.ans[0] = ccp_pkg::ANS_ACK; // R17
              s_d.ans[1] = identWords[31:24];
              s_d.ans[2] = identWords[23:16];
              s_d.ans[3] = identWords[15:8];
              s_d.ans[4] = identWords[7:0];
              s_d.ansLen = 3'd5;
            end
          end
          ccp_pkg::CMD_FAM_IDENT: begin
            if (s_q.nBytes == 3'd2 && sumOk && inAny) begin
              s_d.ans[0] = ccp_pkg::ANS_ACK; // R18
              s_d.ans[1] = PROJECT_NUMBER;
              s_d.ans[2] = FAMILY_CODE[11:4];
              s_d.ans[3] = {FAMILY_CODE[3:0], HW_VERSION};
              s_d.ans[4] = SW_VERSION;
              s_d.ansLen = 3'd5;
            end
          end
          ccp_pkg::CMD_ROM_CHECK: begin
            if (s_q.nBytes == 3'd2 && sumOk && inAny) begin
              s_d.ans[0] = ccp_pkg::ANS_ACK; // R19
              s_d.ans[1] = ROM_CHECKSUM[15:8];
              s_d.ans[2] = ROM_CHECKSUM[7:0];
              s_d.ansLen = 3'd3;
            end
          end
          default: begin
            s_d.ans[0] = ccp_pkg::ANS_NACK; // R25
          end
        endcase
        if (s_d.phase == ccp_pkg::CCP_REPLY && s_d.ansLen > 3'd1) begin
          s_d.ans[s_d.ansLen] = sumPlusOne(s_d.ans, s_d.ansLen); // R26
          s_d.ansLen = s_d.ansLen + 3'd1;
        end
      end
      ccp_pkg::CCP_NVWAIT: begin
        if (s_q.waitCnt >= 32'(NV_WRITE_CYC - 1)) begin
          s_d.ans[0] = ccp_pkg::ANS_ACK; // R10
          s_d.ansLen = 3'd1;
          s_d.phase = ccp_pkg::CCP_REPLY;
        end else begin
          s_d.waitCnt = s_q.waitCnt + 32'd1;
        end
      end
      ccp_pkg::CCP_MEASWAIT: begin
        if (measDone) begin // R16
          s_d.ans[0] = (enabledError && s_q.cmd[0] != ccp_pkg::CMD_SELF_TEST)
                       ? ccp_pkg::ANS_BELL : ccp_pkg::ANS_ACK; // R13
          s_d.ans[1] = measWord0[15:8]; // R14
          s_d.ans[2] = measWord0[7:0];
          s_d.ansLen = 3'd3;
          if (s_q.cmd[0] == ccp_pkg::CMD_SELF_TEST || a1[1]) begin
            s_d.ans[3] = measWord1[15:8]; // R14
            s_d.ans[4] = measWord1[7:0];
            s_d.ansLen = 3'd5;
          end
          s_d.ans[s_d.ansLen] = sumPlusOne(s_d.ans, s_d.ansLen); // R26
          s_d.ansLen = s_d.ansLen + 3'd1;
          s_d.phase = ccp_pkg::CCP_REPLY;
        end
      end
      ccp_pkg::CCP_REPLY: begin
        if (answerTaken) begin
          if (s_q.ansIdx + 3'd1 >= s_q.ansLen) begin
            s_d.phase = ccp_pkg::CCP_IDLE;
            s_d.nBytes = '0;
            s_d.anyTwoWire = 1'b0;
          end else begin
            s_d.ansIdx = s_q.ansIdx + 3'd1;
          end
        end
      end
      default: begin
        s_d.phase = ccp_pkg::CCP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.phase <= ccp_pkg::CCP_IDLE;
      s_q.mode <= ccp_pkg::CCP_WINDOW;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    answerReady = s_q.phase == ccp_pkg::CCP_REPLY; // R23
    answerByte.data = s_q.ans[s_q.ansIdx];
    answerByte.valid = answerReady;
    answerByte.fromTwoWire = s_q.toTwoWire; // R20
    singleWireEnable = s_q.mode != ccp_pkg::CCP_OPER; // R24
    configMode = s_q.mode == ccp_pkg::CCP_CONFIG;
    diagMode = s_q.mode == ccp_pkg::CCP_DIAG;
    regWrite = s_q.regWr;
    regAddr = s_q.cmd[1];
    regWdata = s_q.cmd[2];
    nvStore = s_q.nv;
    nvReadAddr = s_q.cmd[0] == ccp_pkg::CMD_DEV_IDENT ?
                 ccp_pkg::NV_IDENT_HI : s_q.cmd[1][6:0];
    measStart = s_q.measGo;
    measKind = s_q.cmd[0] == ccp_pkg::CMD_SELF_TEST ? 2'h0 :
               s_q.cmd[0] == ccp_pkg::CMD_PRESSURE ? 2'h1 : 2'h2;
    measSel = s_q.cmd[1][1:0];
    testStimulus = s_q.cmd[2];
  end
endmodule
`default_nettype wire

// ==== design/ccp_pkg.sv ====
// Constants, command codes and carrier types of the shared command engine.
// Assumes one system clock at 125 MHz and an asynchronous active-high reset.
// How it works
// R01: Enter config: 84 E5 5E C8, full access
// R02: Config needs window and an unlocked block
// R03: Enter diagnosis: 8C E5 5E D0, restricted
// R04: State entry answers 06 or 15
// R05: Validity by window, config or diagnosis state
// R06: Register read 9B, address 70..7E, answer
// R07: Register write 94, config only, answers
// R08: Nonvolatile read 93, address 00..5F, word answer
// R09: Nonvolatile write 9D, address 00..55, config only
// R10: Acknowledge only after 8 ms store finishes
// R11: Self-test B4, channel bit, stimulus, results
// R12: Pressure query C3, raw/corrected, one/two channels
// R13: Query status 07 when enabled error active
// R14: Query answer carries channel words then checksum
// R15: Temperature query CB, raw/corrected, one/two sensors
// R16: Temperature answer waits for fresh conversion
// R17: Device ident CA CB, four bytes from words 56..57
// R18: Family ident DA DB, project, family, versions
// R19: ROM checksum EA EB, two bytes high first
// R20: Answer to two-wire port if any byte came there
// R21: Controller avoids using both ports at once
// R22: Checksum is byte sum plus one
// R23: Two-wire read unacknowledged until answer ready
// R24: Window opens once; then operational, single-wire off
// R25: Unknown or misplaced command gets negative acknowledge
// R26: Reply checksum uses same sum plus one
package ccp_pkg;
  localparam logic [7:0] CMD_ENTER_CONFIG = 8'h84;
  localparam logic [7:0] CMD_ENTER_DIAG = 8'h8c;
  localparam logic [7:0] CMD_REG_READ = 8'h9b;
  localparam logic [7:0] CMD_REG_WRITE = 8'h94;
  localparam logic [7:0] CMD_NV_FETCH = 8'h93;
  localparam logic [7:0] CMD_NV_STORE = 8'h9d;
  localparam logic [7:0] CMD_SELF_TEST = 8'hb4;
  localparam logic [7:0] CMD_PRESSURE = 8'hc3;
  localparam logic [7:0] CMD_TEMPERATURE = 8'hcb;
  localparam logic [7:0] CMD_DEV_IDENT = 8'hca;
  localparam logic [7:0] CMD_FAM_IDENT = 8'hda;
  localparam logic [7:0] CMD_ROM_CHECK = 8'hea;
  localparam logic [7:0] KEY_BYTE0 = 8'he5;
  localparam logic [7:0] KEY_BYTE1 = 8'h5e;
  localparam logic [7:0] ANS_ACK = 8'h06;
  localparam logic [7:0] ANS_BELL = 8'h07;
  localparam logic [7:0] ANS_NACK = 8'h15;
  localparam logic [7:0] REG_ADDR_LO = 8'h70;
  localparam logic [7:0] REG_ADDR_HI = 8'h7e;
  localparam logic [7:0] NV_READ_HI = 8'h5f;
  localparam logic [7:0] NV_WRITE_HI = 8'h55;
  localparam logic [6:0] NV_IDENT_HI = 7'h56;
  localparam logic [6:0] NV_IDENT_LO = 7'h57;
  localparam int CLK_MHZ = 125;
  localparam int NV_ERASE_MS = 4;
  localparam int NV_PROGRAM_MS = 4;
  localparam int NV_WRITE_CYCLES = (NV_ERASE_MS + NV_PROGRAM_MS) * 1000 *
                                   1000 * CLK_MHZ / 1000;
  localparam int WINDOW_MS = 100;
  localparam int WINDOW_CYCLES = WINDOW_MS * 1000 * CLK_MHZ;
  localparam int MAX_CMD = 5;
  localparam int MAX_ANS = 6;

  typedef enum {
    CCP_IDLE, CCP_EXEC, CCP_NVWAIT, CCP_MEASWAIT, CCP_REPLY
  } ccp_phase_t;

  typedef enum {CCP_WINDOW, CCP_OPER, CCP_CONFIG, CCP_DIAG} ccp_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic fromTwoWire;
  } ccp_byte_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [15:0] data;
  } ccp_nv_req_t;
endpackage

// ==== test/ccp_checker.sv ====
// Concurrent checks on the shared command engine ports.
// Assumes one clk_sys domain with asynchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module ccp_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Answer side
  input wire ccp_pkg::ccp_byte_t answerByte,
  input wire logic answerReady,
  input wire logic answerTaken,
  input wire logic singleWireEnable,
  // State and writes
  input wire logic configMode,
  input wire logic diagMode,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire ccp_pkg::ccp_nv_req_t nvStore
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_store;
    nvStore.valid;
  endsequence
  sequence s_quiet;
    !answerReady [*8];
  endsequence
  a_answer_stands: assert property (
    answerReady && !answerTaken |=> answerReady && $stable(answerByte))
    else $error("answer byte moved before taken");
  a_modes_exclusive: assert property (!(configMode && diagMode))
    else $error("both modes active");
  a_config_sticky: assert property (configMode |=> configMode)
    else $error("config mode left");
  a_diag_sticky: assert property (diagMode |=> diagMode)
    else $error("diagnosis mode left");
  a_window_once: assert property (!singleWireEnable |=> !singleWireEnable)
    else $error("single-wire port came back");
  a_store_wait: assert property (s_store |=> s_quiet)
    else $error("answer before store finished");
  a_store_range: assert property (
    s_store |-> configMode && nvStore.addr <= 7'h55)
    else $error("store outside config or range");
  a_reg_range: assert property (
    regWrite |-> configMode && regAddr >= 8'h70 && regAddr <= 8'h7e)
    else $error("register write outside config or range");
  a_diag_readonly: assert property (
    diagMode |-> !regWrite && !nvStore.valid)
    else $error("write in diagnosis mode");
endmodule
bind ccp_shared_command_engine ccp_checker u_chk (.clk_sys, .rst,
  .answerByte, .answerReady, .answerTaken, .singleWireEnable, .configMode,
  .diagMode, .regWrite, .regAddr, .nvStore);
`default_nettype wire

// ==== test/ccp_host_model.sv ====
// Bus-master model: frames commands byte by byte and drains answers.
// Assumes the engine samples strobes and answerTaken at clk_sys edges.
`timescale 1ns/1ps
`default_nettype none
module ccp_host_model (
  // Clock
  input wire logic clk_sys,
  // Command bytes
  output ccp_pkg::ccp_byte_t twoWireByte,
  output ccp_pkg::ccp_byte_t singleWireByte,
  output logic cmdEnd,
  // Answer bytes
  input wire ccp_pkg::ccp_byte_t answerByte,
  input wire logic answerReady,
  output logic answerTaken
);
  logic [7:0] ans [6];
  logic ansTwo;
  initial begin
    twoWireByte = '0;
    singleWireByte = '0;
    cmdEnd = 1'b0;
    answerTaken = 1'b0;
  end
  // Idle data shows the inverted byte so stale data never looks fresh
  task automatic send(input logic [31:0] body, input int nb,
      input logic [4:0] two, input logic bad);
    logic [7:0] b;
    logic [7:0] sum;
    sum = 8'h01;
    for (int i = 0; i <= nb; i++) begin
      b = (i == nb) ? sum ^ {7'h0, bad} : body[31-8*i -: 8];
      sum = sum + b;
      @(posedge clk_sys);
      twoWireByte <= '{b, two[i], 1'b1};
      singleWireByte <= '{b, !two[i], 1'b0};
      @(posedge clk_sys);
      twoWireByte <= '{~b, 1'b0, 1'b1};
      singleWireByte <= '{~b, 1'b0, 1'b0};
    end
    @(posedge clk_sys);
    cmdEnd <= 1'b1;
    @(posedge clk_sys);
    cmdEnd <= 1'b0;
  endtask
  // Polls for each answer byte under a bound, then takes it
  task automatic take(input int n);
    int k;
    for (int i = 0; i < 6; i++) ans[i] = 'x;
    for (int i = 0; i < n; i++) begin
      k = 0;
      // Sample settled outputs mid-cycle, away from the launching edge
      do begin
        @(negedge clk_sys);
        k++;
      end while (!answerReady && k < 400);
      if (answerReady) begin
        ans[i] = answerByte.data;
        if (i == 0) ansTwo = answerByte.fromTwoWire;
        @(posedge clk_sys);
        answerTaken <= 1'b1;
        @(posedge clk_sys);
        answerTaken <= 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== test/ccp_shared_command_engine_bench.sv ====
// Self-checking bench: command sequences through the host model.
// Assumes the checker is bound to the engine by its own file.
`timescale 1ns/1ps
`default_nettype none
module ccp_shared_command_engine_bench;
  localparam logic [7:0] PROJ = 8'h11; // Arbitrary value
  localparam logic [11:0] FAM = 12'h123; // Arbitrary value
  localparam logic [3:0] HWV = 4'h2;
  localparam logic [7:0] SWV = 8'h03;
  localparam logic [15:0] ROMS = 16'h5aa5;
  localparam logic [15:0] W0 = 16'h0abc;
  localparam logic [15:0] W1 = 16'h0def;
  localparam logic [39:0] NAK = 40'h15_0000_0000;
  localparam logic [39:0] ACK = 40'h06_0000_0000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic unlockedBlock = 1'b1;
  logic enabledError = 1'b0;
  logic measDone = 1'b0;
  logic measStart, cmdEnd, answerTaken, answerReady;
  logic regWrite;
  logic [7:0] regAddr, regWdata, testStimulus;
  logic [1:0] measKind, measSel;
  ccp_pkg::ccp_nv_req_t nvStore;
  logic [15:0] regSeen;
  logic [22:0] nvSeen;
  logic [11:0] measSeen;
  logic singleWireEnable, configMode, diagMode;
  ccp_pkg::ccp_byte_t twoWireByte, singleWireByte, answerByte;
  int err_count = 0;
  int check_count = 0;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) measDone <= measStart;
  // Record what the engine hands to the register, store and measure sides
  always @(posedge clk_sys) begin
    if (regWrite) regSeen <= {regAddr, regWdata};
    if (nvStore.valid) nvSeen <= {nvStore.addr, nvStore.data};
    if (measStart) measSeen <= {measKind, measSel, testStimulus};
  end
  ccp_shared_command_engine #(.WINDOW_CYC(400), .NV_WRITE_CYC(20),
    .PROJECT_NUMBER(PROJ), .FAMILY_CODE(FAM), .HW_VERSION(HWV),
    .SW_VERSION(SWV), .ROM_CHECKSUM(ROMS)) DUT (
    .clk_sys(clk_sys), .rst(rst), .twoWireByte(twoWireByte),
    .singleWireByte(singleWireByte), .cmdEnd(cmdEnd),
    .answerByte(answerByte), .answerTaken(answerTaken),
    .answerReady(answerReady), .singleWireEnable(singleWireEnable),
    .unlockedBlock(unlockedBlock), .enabledError(enabledError),
    .configMode(configMode), .diagMode(diagMode), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(8'h3c),
    .nvStore(nvStore),
    .nvReadAddr(), .nvRdata(16'hbeef), .identWords(32'h0102_0304),
    .measStart(measStart), .measKind(measKind), .measSel(measSel),
    .testStimulus(testStimulus),
    .measDone(measDone), .measWord0(W0), .measWord1(W1));
  ccp_host_model u_host (.clk_sys(clk_sys), .twoWireByte(twoWireByte),
    .singleWireByte(singleWireByte), .cmdEnd(cmdEnd),
    .answerByte(answerByte), .answerReady(answerReady),
    .answerTaken(answerTaken));
  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [31:0] body, input int nb,
      input logic [4:0] two, input logic bad, input logic [39:0] exp,
      input int ne);
    logic [7:0] sum;
    int n;
    n = ne + ((ne > 1) ? 1 : 0);
    u_host.send(body, nb, two, bad);
    u_host.take(n);
    sum = 8'h01;
    for (int i = 0; i < n; i++) begin
      chk("answer byte", (i < ne) ? exp[39-8*i -: 8] : sum, u_host.ans[i]);
      sum = sum + exp[39-8*i -: 8];
    end
    chk("answer route", {7'h0, |two}, {7'h0, u_host.ansTwo});
  endtask
  task automatic do_reset(input logic unl);
    @(posedge clk_sys);
    rst <= 1'b1;
    unlockedBlock <= unl;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    end_of_test;
  end
  initial begin
    do_reset(1'b1);
    cmd(32'h9b70_0000, 2, 5'h00, 1'b0, NAK, 1);
    cmd(32'h84e5_5e00, 3, 5'h00, 1'b1, NAK, 1);
    cmd(32'h84e5_5f00, 3, 5'h00, 1'b0, NAK, 1);
    cmd(32'h8ce5_5e00, 3, 5'h00, 1'b0, ACK, 1);
    chk("diag mode", 8'h01, {7'h0, diagMode});
    cmd(32'h9470_1200, 3, 5'h00, 1'b0, NAK, 1);
    cmd(32'h935f_0000, 2, 5'h00, 1'b0, 40'h06_beef_0000, 3);
    cmd(32'h9360_0000, 2, 5'h00, 1'b0, NAK, 1);
    cmd(32'hca00_0000, 1, 5'h00, 1'b0, 40'h06_0102_0304, 5);
    $display("test diagnosis done");
    do_reset(1'b0);
    cmd(32'h84e5_5e00, 3, 5'h1f, 1'b0, NAK, 1);
    do_reset(1'b1);
    cmd(32'h84e5_5e00, 3, 5'h02, 1'b0, ACK, 1);
    chk("config mode", 8'h01, {7'h0, configMode});
    cmd(32'h9b7e_0000, 2, 5'h1f, 1'b0, 40'h06_3c00_0000, 2);
    cmd(32'h9b7f_0000, 2, 5'h1f, 1'b0, NAK, 1);
    cmd(32'h9470_1200, 3, 5'h1f, 1'b0, ACK, 1);
    chk("reg addr", 8'h70, regSeen[15:8]);
    chk("reg data", 8'h12, regSeen[7:0]);
    cmd(32'h946f_1200, 3, 5'h1f, 1'b0, NAK, 1);
    cmd(32'h9d55_1234, 4, 5'h1f, 1'b0, ACK, 1);
    chk("nv addr", 8'h55, {1'b0, nvSeen[22:16]});
    chk("nv high", 8'h12, nvSeen[15:8]);
    chk("nv low", 8'h34, nvSeen[7:0]);
    cmd(32'h9d56_1234, 4, 5'h1f, 1'b0, NAK, 1);
    cmd(32'hb401_a500, 3, 5'h1f, 1'b0, {8'h06, W0, W1}, 5);
    chk("meas kind", 8'h00, {6'h0, measSeen[11:10]});
    chk("meas channel", 8'h01, {6'h0, measSeen[9:8]});
    chk("meas stimulus", 8'ha5, measSeen[7:0]);
    enabledError <= 1'b1;
    cmd(32'hc303_0000, 2, 5'h1f, 1'b0, {8'h07, W0, W1}, 5);
    cmd(32'hc300_0000, 2, 5'h1f, 1'b0, {8'h07, W0, 16'h0}, 3);
    cmd(32'hcb00_0000, 2, 5'h1f, 1'b1, NAK, 1);
    enabledError <= 1'b0;
    cmd(32'hcb02_0000, 2, 5'h1f, 1'b0, {8'h06, W0, W1}, 5);
    cmd(32'hda00_0000, 1, 5'h1f, 1'b0,
      {8'h06, PROJ, FAM[11:4], FAM[3:0], HWV, SWV}, 5);
    cmd(32'hea00_0000, 1, 5'h1f, 1'b0, {8'h06, ROMS, 16'h0}, 3);
    cmd(32'h5500_0000, 1, 5'h1f, 1'b0, NAK, 1);
    $display("test configuration done");
    do_reset(1'b1);
    repeat (410) @(posedge clk_sys);
    chk("single-wire enable", 8'h00, {7'h0, singleWireEnable});
    cmd(32'h84e5_5e00, 3, 5'h1f, 1'b0, NAK, 1);
    $display("test window done");
    end_of_test;
  end
endmodule
`default_nettype wire
